// *** common/ucf_defines.svh ***
`ifndef UCF_DEFINES_SVH
`define UCF_DEFINES_SVH

// Register indices; byte address is four times the index
`define UCF_IDX_CTRL1 6'h13
`define UCF_IDX_CTRL2 6'h14
`define UCF_IDX_CTRL3 6'h15
`define UCF_IDX_STAT1 6'h16
`define UCF_IDX_DATA 6'h18

// Control register one
`define UCF_B_UART_ON 6
`define UCF_B_NINE_BIT 4
`define UCF_B_RESUME_SEL 3
`define UCF_B_PARITY_ON 1
`define UCF_B_PARITY_ODD 0

// Control register two
`define UCF_B_TX_EMPTY_IE 7
`define UCF_B_TX_DONE_IE 6
`define UCF_B_RX_FULL_IE 5
`define UCF_B_RX_IDLE_IE 4
`define UCF_B_TX_ON 3
`define UCF_B_RX_ON 2
`define UCF_B_RX_STANDBY 1
`define UCF_B_SEND_BRK 0

// Control register three
`define UCF_B_RX_NINTH 7
`define UCF_B_TX_NINTH 6
`define UCF_B_DMA_RX 5
`define UCF_B_DMA_TX 4
`define UCF_B_OVR_IE 3
`define UCF_B_NOISE_IE 2
`define UCF_B_FRAME_IE 1
`define UCF_B_PARITY_IE 0

// Status register one
`define UCF_B_ST_TX_EMPTY 7
`define UCF_B_ST_TX_DONE 6
`define UCF_B_ST_RX_FULL 5
`define UCF_B_ST_IDLE 4
`define UCF_B_ST_OVR 3
`define UCF_B_ST_NOISE 2
`define UCF_B_ST_FRAME 1
`define UCF_B_ST_PARITY 0

// Frame lengths in bit times
`define UCF_LEN_SHORT 4'ha
`define UCF_LEN_LONG 4'hb
`define UCF_LEN_TAIL 4'h1

// Reset value and default bit time in clock cycles
`define UCF_RST_CTRL 8'h00
`define UCF_BIT_CYCLES 16

`endif

// *** common/ucf_pkg.sv ***
package ucf_pkg;

    typedef enum logic [2:0] {
        UCF_K_NONE,
        UCF_K_BRK,
        UCF_K_TAIL,
        UCF_K_ONES,
        UCF_K_DATA
    } ucf_kind_t;

    typedef enum logic {
        UCF_TX_IDLE,
        UCF_TX_SHIFT
    } ucf_tx_state_t;

endpackage : ucf_pkg

// *** common/ucf_tx_if.sv ***
`timescale 1ns/10ps

interface ucf_tx_if;
    logic enable;
    logic req;
    logic [10:0] frame;
    logic [3:0] len;
    logic taken;
    logic busy;
    logic line;

    modport ctl (output enable, output req, output frame, output len, input taken, input busy, input line);
    modport shifter (input enable, input req, input frame, input len, output taken, output busy, output line);
endinterface : ucf_tx_if

// *** hdl/ucf_tx.sv ***
`timescale 1ns/10ps
`include "ucf_defines.svh"

module ucf_tx #(
    parameter int BIT_CYC = `UCF_BIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    ucf_tx_if.shifter txi
);
    localparam int CW = (BIT_CYC > 1) ? $clog2(BIT_CYC) : 1;
    localparam logic [CW-1:0] CYC_LAST = CW'(BIT_CYC - 1);

    generate
        if (BIT_CYC < 1) begin : g_chk
            $error("BIT_CYC must be at least one");
        end
    endgenerate

    ucf_pkg::ucf_tx_state_t state_q;
    logic [10:0] shift_q;
    logic [3:0] left_q;
    logic [CW-1:0] cyc_q;
    logic bit_end;

    assign bit_end = (state_q == ucf_pkg::UCF_TX_SHIFT) && (cyc_q == CYC_LAST);
    // Load when idle, or straight after the last bit so frames run back to back
    assign txi.taken = txi.enable && txi.req &&
        ((state_q == ucf_pkg::UCF_TX_IDLE) || (bit_end && left_q == `UCF_LEN_TAIL));
    assign txi.busy = (state_q == ucf_pkg::UCF_TX_SHIFT);
    assign txi.line = (state_q == ucf_pkg::UCF_TX_SHIFT) ? shift_q[0] : 1'b1;

    always_ff @(posedge clk) begin
        if (rst || !txi.enable) begin
            state_q <= ucf_pkg::UCF_TX_IDLE;
            shift_q <= '1;
            left_q <= '0;
            cyc_q <= '0;
        end else if (txi.taken) begin
            state_q <= ucf_pkg::UCF_TX_SHIFT;
            shift_q <= txi.frame;
            left_q <= txi.len;
            cyc_q <= '0;
        end else begin
            case (state_q)
                ucf_pkg::UCF_TX_SHIFT: begin
                    if (bit_end) begin
                        cyc_q <= '0;
                        shift_q <= {1'b1, shift_q[10:1]};
                        left_q <= left_q - 4'h1;
                        if (left_q == `UCF_LEN_TAIL) begin
                            state_q <= ucf_pkg::UCF_TX_IDLE;
                        end
                    end else begin
                        cyc_q <= cyc_q + CW'(1);
                    end
                end
                default: begin
                    cyc_q <= '0;
                end
            endcase
        end
    end

endmodule : ucf_tx

// *** hdl/ucf_top.sv ***
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "ucf_defines.svh"

module ucf_top #(
    parameter int ADDR_W = 8,
    parameter int BIT_CYC = `UCF_BIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic tx_pin,
    input wire logic rx_load,
    input wire logic [8:0] rx_char,
    input wire logic rx_idle_event,
    input wire logic rx_full_flag,
    input wire logic rx_idle_flag,
    input wire logic overrun_flag,
    input wire logic noise_flag,
    input wire logic frame_err_flag,
    input wire logic parity_err_flag,
    output logic rx_enable,
    output logic uart_enable,
    output logic nine_bit_char_sel,
    output logic parity_on,
    output logic parity_odd_sel,
    output logic tx_irq,
    output logic rx_irq,
    output logic err_irq
);
    generate
        if (ADDR_W < 7) begin : g_chk
            $error("ADDR_W too small for the register map");
        end
    endgenerate

    // Bus slave: one wait cycle, then the answer
    logic ack_q;
    logic [31:0] readdata_q;
    logic wr_ok;
    logic [ADDR_W-3:0] idx;
    logic [7:0] wbyte;

    assign waitrequest = (read || write) && !ack_q;
    assign wr_ok = write && ack_q && byteenable[0];
    assign idx = address[ADDR_W-1:2];
    assign wbyte = writedata[7:0];
    assign readdata = readdata_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read || write) && !ack_q;
        end
    end

    // Control register one
    logic uart_on_q, nine_bit_q, resume_sel_q, parity_on_q, parity_odd_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            uart_on_q <= 1'b0;
            nine_bit_q <= 1'b0;
            resume_sel_q <= 1'b0;
            parity_on_q <= 1'b0;
            parity_odd_q <= 1'b0;
        end else if (wr_ok && idx == (ADDR_W-2)'(`UCF_IDX_CTRL1)) begin
            uart_on_q <= wbyte[`UCF_B_UART_ON];
            nine_bit_q <= wbyte[`UCF_B_NINE_BIT];
            resume_sel_q <= wbyte[`UCF_B_RESUME_SEL];
            parity_on_q <= wbyte[`UCF_B_PARITY_ON];
            parity_odd_q <= wbyte[`UCF_B_PARITY_ODD];
        end
    end

    // Control register two
    logic [7:0] ctrl2_q;
    logic wr_ctrl2, standby_wake;

    assign wr_ctrl2 = wr_ok && idx == (ADDR_W-2)'(`UCF_IDX_CTRL2);
    assign standby_wake = resume_sel_q ? (rx_load && (nine_bit_q ? rx_char[8] : rx_char[7]))
                                       : rx_idle_event;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl2_q <= `UCF_RST_CTRL;
        end else begin
            if (wr_ctrl2) begin
                ctrl2_q <= wbyte;
            end
            if (standby_wake) begin
                ctrl2_q[`UCF_B_RX_STANDBY] <= 1'b0;
            end
        end
    end

    logic tx_on, rx_on, rx_standby, send_brk;

    assign tx_on = ctrl2_q[`UCF_B_TX_ON];
    assign rx_on = ctrl2_q[`UCF_B_RX_ON];
    assign rx_standby = ctrl2_q[`UCF_B_RX_STANDBY];
    assign send_brk = ctrl2_q[`UCF_B_SEND_BRK];

    // Control register three, writable part
    logic tx_ninth_bit_q, dma_rx_q, dma_tx_q;
    logic ovr_ie_q, noise_ie_q, frame_ie_q, parity_ie_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            dma_rx_q <= 1'b0;
            dma_tx_q <= 1'b0;
            ovr_ie_q <= 1'b0;
            noise_ie_q <= 1'b0;
            frame_ie_q <= 1'b0;
            parity_ie_q <= 1'b0;
        end else if (wr_ok && idx == (ADDR_W-2)'(`UCF_IDX_CTRL3)) begin
            dma_rx_q <= wbyte[`UCF_B_DMA_RX];
            dma_tx_q <= wbyte[`UCF_B_DMA_TX];
            ovr_ie_q <= wbyte[`UCF_B_OVR_IE];
            noise_ie_q <= wbyte[`UCF_B_NOISE_IE];
            frame_ie_q <= wbyte[`UCF_B_FRAME_IE];
            parity_ie_q <= wbyte[`UCF_B_PARITY_IE];
        end
    end

    // Ninth bits and data buffers keep their value through reset
    logic rx_ninth_bit_q;
    logic [7:0] rx_data_q, tx_data_q;
    logic wr_data;

    assign wr_data = wr_ok && idx == (ADDR_W-2)'(`UCF_IDX_DATA);

    always_ff @(posedge clk) begin
        if (wr_ok && idx == (ADDR_W-2)'(`UCF_IDX_CTRL3)) begin
            tx_ninth_bit_q <= wbyte[`UCF_B_TX_NINTH];
        end
    end

    always_ff @(posedge clk) begin
        if (rx_load) begin
            rx_data_q <= rx_char[7:0];
            rx_ninth_bit_q <= nine_bit_q ? rx_char[8] : rx_char[7];
        end
    end

    always_ff @(posedge clk) begin
        if (wr_data) begin
            tx_data_q <= wbyte;
        end
    end

    // Transmit control
    ucf_tx_if txi();
    ucf_pkg::ucf_kind_t kind;
    logic tx_buf_empty_q, ones_pend_q, tail_q, tx_on_old_q, tx_done;
    logic [3:0] flen;
    logic [7:0] par_src;
    logic par_bit, ninth;
    logic [10:0] data_frame;

    assign flen = nine_bit_q ? `UCF_LEN_LONG : `UCF_LEN_SHORT;
    assign par_src = nine_bit_q ? tx_data_q : {1'b0, tx_data_q[6:0]};
    assign par_bit = (^par_src) ^ parity_odd_q;
    assign ninth = parity_on_q ? par_bit : tx_ninth_bit_q;
    assign data_frame = nine_bit_q ? {1'b1, ninth, tx_data_q, 1'b0}
                                   : {2'b11, parity_on_q ? par_bit : tx_data_q[7], tx_data_q[6:0], 1'b0};

    always_comb begin
        kind = ucf_pkg::UCF_K_NONE;
        if (send_brk) begin
            kind = ucf_pkg::UCF_K_BRK;
        end else if (tail_q) begin
            kind = ucf_pkg::UCF_K_TAIL;
        end else if (ones_pend_q) begin
            kind = ucf_pkg::UCF_K_ONES;
        end else if (!tx_buf_empty_q) begin
            kind = ucf_pkg::UCF_K_DATA;
        end
    end

    always_comb begin
        txi.frame = data_frame;
        txi.len = flen;
        case (kind)
            ucf_pkg::UCF_K_BRK: begin
                txi.frame = '0;
            end
            ucf_pkg::UCF_K_TAIL: begin
                txi.frame = '1;
                txi.len = `UCF_LEN_TAIL;
            end
            ucf_pkg::UCF_K_ONES: begin
                txi.frame = '1;
            end
            default: begin
                txi.frame = data_frame;
            end
        endcase
    end

    assign txi.enable = uart_on_q;
    assign txi.req = tx_on && (kind != ucf_pkg::UCF_K_NONE);

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_on_old_q <= 1'b0;
            ones_pend_q <= 1'b0;
            tail_q <= 1'b0;
        end else begin
            tx_on_old_q <= tx_on;
            if (!uart_on_q) begin
                ones_pend_q <= 1'b0;
                tail_q <= 1'b0;
            end else if (tx_on && !tx_on_old_q) begin
                ones_pend_q <= 1'b1;
            end else if (txi.taken) begin
                case (kind)
                    ucf_pkg::UCF_K_BRK: begin
                        ones_pend_q <= 1'b0;
                        tail_q <= 1'b1;
                    end
                    ucf_pkg::UCF_K_TAIL: tail_q <= 1'b0;
                    ucf_pkg::UCF_K_ONES: ones_pend_q <= 1'b0;
                    default: tail_q <= tail_q;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_buf_empty_q <= 1'b1;
        end else if (!uart_on_q || (txi.taken && kind == ucf_pkg::UCF_K_DATA)) begin
            tx_buf_empty_q <= 1'b1;
        end else if (wr_data) begin
            tx_buf_empty_q <= 1'b0;
        end
    end

    assign tx_done = !uart_on_q || (tx_buf_empty_q && !txi.busy && !txi.req);

    ucf_tx #(
        .BIT_CYC(BIT_CYC)
    ) u_tx (
        .clk(clk),
        .rst(rst),
        .txi(txi)
    );

    // Interrupt requests
    assign tx_irq = uart_on_q && ((ctrl2_q[`UCF_B_TX_EMPTY_IE] && tx_buf_empty_q) ||
                                  (ctrl2_q[`UCF_B_TX_DONE_IE] && tx_done));
    assign rx_irq = !rx_standby && ((ctrl2_q[`UCF_B_RX_FULL_IE] && rx_full_flag) ||
                                    (ctrl2_q[`UCF_B_RX_IDLE_IE] && rx_idle_flag));
    assign err_irq = (ovr_ie_q && overrun_flag) || (noise_ie_q && noise_flag) ||
                     (frame_ie_q && frame_err_flag) || (parity_ie_q && parity_err_flag);

    assign tx_pin = txi.line;
    assign rx_enable = uart_on_q && rx_on;
    assign uart_enable = uart_on_q;
    assign nine_bit_char_sel = nine_bit_q;
    assign parity_on = parity_on_q;
    assign parity_odd_sel = parity_odd_q;

    // Read mux
    logic [7:0] rbyte;

    always_comb begin
        rbyte = 8'h00;
        if (idx == (ADDR_W-2)'(`UCF_IDX_CTRL1)) begin
            rbyte[`UCF_B_UART_ON] = uart_on_q;
            rbyte[`UCF_B_NINE_BIT] = nine_bit_q;
            rbyte[`UCF_B_RESUME_SEL] = resume_sel_q;
            rbyte[`UCF_B_PARITY_ON] = parity_on_q;
            rbyte[`UCF_B_PARITY_ODD] = parity_odd_q;
        end else if (idx == (ADDR_W-2)'(`UCF_IDX_CTRL2)) begin
            rbyte = ctrl2_q;
        end else if (idx == (ADDR_W-2)'(`UCF_IDX_CTRL3)) begin
            rbyte = {rx_ninth_bit_q, tx_ninth_bit_q, dma_rx_q, dma_tx_q,
                     ovr_ie_q, noise_ie_q, frame_ie_q, parity_ie_q};
        end else if (idx == (ADDR_W-2)'(`UCF_IDX_STAT1)) begin
            rbyte = {tx_buf_empty_q, tx_done, rx_full_flag, rx_idle_flag,
                     overrun_flag, noise_flag, frame_err_flag, parity_err_flag};
        end else if (idx == (ADDR_W-2)'(`UCF_IDX_DATA)) begin
            rbyte = rx_data_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            readdata_q <= '0;
        end else if (read && !ack_q) begin
            readdata_q <= {24'h000000, rbyte};
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    brk_zero_line_a: assert property ((txi.taken && kind == ucf_pkg::UCF_K_BRK) |=> !tx_pin [*8])
        else $error("break frame not driven low");
    preamble_queue_a: assert property ((uart_on_q && tx_on && !$past(tx_on)) |=> ones_pend_q)
        else $error("preamble not queued on transmitter enable");
    tail_after_brk_a: assert property ((txi.taken && kind == ucf_pkg::UCF_K_BRK) |=> tail_q)
        else $error("one bit not queued after break");
    idle_when_off_a: assert property ((!tx_on && !txi.busy) |=> (tx_pin && !txi.busy))
        else $error("line not idle high");
    off_flags_a: assert property (!uart_on_q |-> (tx_done && !tx_irq) ##1 tx_buf_empty_q)
        else $error("module off did not set empty and done");
    standby_mask_a: assert property (rx_standby |-> !rx_irq)
        else $error("receiver request during standby");
    wake_clear_a: assert property ((rx_standby && standby_wake) |=> !rx_standby)
        else $error("standby not ended by wake event");
    ninth_copy_a: assert property ((rx_load && !nine_bit_q) |=> rx_ninth_bit_q == $past(rx_char[7]))
        else $error("ninth bit not a copy of bit 7");
    frame_len_a: assert property ((txi.taken && kind == ucf_pkg::UCF_K_DATA) |->
        (txi.len == (nine_bit_q ? `UCF_LEN_LONG : `UCF_LEN_SHORT)) && !txi.frame[0] && txi.frame[txi.len - 4'h1])
        else $error("data frame length wrong");
    err_req_a: assert property ((frame_ie_q && frame_err_flag) |-> err_irq)
        else $error("framing error request missing");
    bus_answer_a: assert property ((read || write) && !ack_q |=> !waitrequest)
        else $error("bus answer late");

    cov_data_c: cover property (txi.taken && kind == ucf_pkg::UCF_K_DATA);
    cov_brk_c: cover property (txi.taken && kind == ucf_pkg::UCF_K_BRK);
    cov_tail_c: cover property (txi.taken && kind == ucf_pkg::UCF_K_TAIL);
    cov_wake_c: cover property (rx_standby && standby_wake);

endmodule : ucf_top

// *** dv/ucf_far_end.sv ***
`timescale 1ns/10ps

module ucf_far_end #(
    parameter int BIT_CYC = 2
) (
    input wire logic clk,
    input wire logic tx_pin,
    input wire logic nine,
    input wire logic listen,
    output logic frame_valid,
    output logic [9:0] frame_bits
);
    logic [9:0] acc;
    int n;

    // Samples each bit once per bit time, starting at the first low cycle
    initial begin
        frame_valid = 1'b0;
        frame_bits = 10'h000;
        forever begin
            @(posedge clk);
            frame_valid <= 1'b0;
            if (listen && tx_pin === 1'b0) begin
                acc = 10'h000;
                n = nine ? 10 : 9;
                for (int i = 0; i < n; i++) begin
                    repeat (BIT_CYC) @(posedge clk);
                    acc[i] = tx_pin;
                end
                frame_bits <= acc;
                frame_valid <= 1'b1;
            end
        end
    end
endmodule : ucf_far_end

// *** dv/tb_uart_control_format.sv ***
`timescale 1ns/10ps
`include "ucf_defines.svh"

module tb_uart_control_format;
    localparam int BC = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest, tx_pin, rx_enable, uart_enable, nine_sel, par_on, par_odd, tx_irq, rx_irq, err_irq;
    logic rx_load = 1'b0;
    logic [8:0] rx_char = 9'h000;
    logic rx_idle_event = 1'b0;
    logic [5:0] flags = 6'h00;
    logic listen = 1'b1;
    logic frame_valid;
    logic [9:0] frame_bits;
    logic [31:0] exp_q[$];
    logic [9:0] frm_q[$];
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;

    always #50 clk = ~clk;

    ucf_top #(.ADDR_W(8), .BIT_CYC(BC)) u_dut (.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .tx_pin(tx_pin), .rx_load(rx_load), .rx_char(rx_char),
        .rx_idle_event(rx_idle_event), .rx_full_flag(flags[5]), .rx_idle_flag(flags[4]),
        .overrun_flag(flags[3]), .noise_flag(flags[2]), .frame_err_flag(flags[1]),
        .parity_err_flag(flags[0]), .rx_enable(rx_enable), .uart_enable(uart_enable),
        .nine_bit_char_sel(nine_sel), .parity_on(par_on), .parity_odd_sel(par_odd),
        .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));

    ucf_far_end #(.BIT_CYC(BC)) u_far (.clk(clk), .tx_pin(tx_pin), .nine(nine_sel), .listen(listen),
        .frame_valid(frame_valid), .frame_bits(frame_bits));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        read <= ~wr;
        write <= wr;
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        byteenable <= 4'hf;
        do @(posedge clk); while (waitrequest);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, idx, 8'h00);
    endtask : rd

    task automatic pulse(input logic ld, input logic [8:0] c);
        rx_char <= c;
        rx_load <= ld;
        rx_idle_event <= ~ld;
        @(posedge clk);
        rx_load <= 1'b0;
        rx_idle_event <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse

    task automatic wait_lvl(input logic v);
        for (int k = 0; k < 2000 && tx_pin !== v; k++) @(posedge clk);
        chk("line_level", 32'(tx_pin), 32'(v));
    endtask : wait_lvl

    task automatic wait_frames();
        for (int k = 0; k < 3000 && frm_q.size() > 0; k++) @(posedge clk);
        chk("frames_left", 32'(frm_q.size()), 32'h0);
    endtask : wait_frames

    task automatic hold(input logic v, input int n, output int bad);
        bad = 0;
        repeat (n) begin
            @(posedge clk);
            if (tx_pin !== v) bad++;
        end
    endtask : hold

    // Bits after the start bit, first sent in bit 0
    function automatic logic [9:0] frm(input logic [7:0] d, input logic t8, input logic nine, input logic par,
            input logic odd);
        logic p;
        p = (nine ? ^d : ^d[6:0]) ^ odd;
        if (!nine) frm = par ? {2'b01, p, d[6:0]} : {2'b01, d};
        else frm = par ? {1'b1, p, d} : {1'b1, t8, d};
    endfunction : frm

    always @(posedge clk) begin
        if (read && !waitrequest) chk("readdata", readdata, exp_q.pop_front());
        if (frame_valid) chk("frame", 32'(frame_bits), 32'(frm_q.pop_front()));
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        logic [8:0] r;
        logic [7:0] d;
        int t0;
        int bad;
        void'($urandom(32'hcb83));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`UCF_IDX_STAT1, 8'hc0);
        rd(`UCF_IDX_CTRL2, 8'h00);
        rd(6'h3f, 8'h00);
        chk("irqs", {29'h0, tx_irq, rx_irq, err_irq}, 32'h0);
        $display("test reset done");
        wr(`UCF_IDX_CTRL1, 8'h40);
        for (int i = 0; i < 24; i++) begin
            r = 9'($urandom);
            flags <= 6'($urandom);
            wr(`UCF_IDX_CTRL2, {r[3:0], 1'b0, r[4], 2'b00});
            wr(`UCF_IDX_CTRL3, {4'h0, r[8:5]});
            rd(`UCF_IDX_CTRL2, {r[3:0], 1'b0, r[4], 2'b00});
            chk("tx_irq", 32'(tx_irq), 32'(r[3] | r[2]));
            chk("rx_irq", 32'(rx_irq), 32'((r[1] & flags[5]) | (r[0] & flags[4])));
            chk("err_irq", 32'(err_irq), 32'(|(r[8:5] & flags[3:0])));
            chk("rx_enable", 32'(rx_enable), 32'(r[4]));
        end
        $display("test irq done");
        wr(`UCF_IDX_CTRL3, 8'h00);
        flags <= 6'h20;
        wr(`UCF_IDX_CTRL2, 8'h26);
        chk("standby_rx_irq", 32'(rx_irq), 32'h0);
        pulse(1'b0, 9'h000);
        chk("woken_rx_irq", 32'(rx_irq), 32'h1);
        rd(`UCF_IDX_CTRL2, 8'h24);
        wr(`UCF_IDX_CTRL1, 8'h48);
        wr(`UCF_IDX_CTRL2, 8'h26);
        pulse(1'b0, 9'h000);
        chk("idle_no_wake", 32'(rx_irq), 32'h0);
        pulse(1'b1, 9'h080);
        chk("mark_wake", 32'(rx_irq), 32'h1);
        rd(`UCF_IDX_CTRL2, 8'h24);
        for (int i = 0; i < 4; i++) begin
            wr(`UCF_IDX_CTRL1, {3'b010, i[1], 4'h0});
            pulse(1'b1, i[0] ? 9'h100 : 9'h080);
            rd(`UCF_IDX_CTRL3, {~(i[1] ^ i[0]), 7'h00});
        end
        wr(`UCF_IDX_CTRL3, 8'h40);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`UCF_IDX_CTRL3, 8'hc0);
        $display("test receive side done");
        flags <= 6'h00;
        wr(`UCF_IDX_CTRL1, 8'h40);
        wr(`UCF_IDX_CTRL2, 8'h08);
        t0 = cyc;
        frm_q.push_back(frm(8'h5a, 1'b0, 1'b0, 1'b0, 1'b0));
        wr(`UCF_IDX_DATA, 8'h5a);
        wait_lvl(1'b0);
        chk("preamble", 32'(cyc - t0 >= 10 * BC && cyc - t0 <= 10 * BC + 8), 32'h1);
        wait_frames();
        for (int m = 0; m < 4; m++) begin
            r = 9'($urandom);
            d = 8'($urandom);
            wr(`UCF_IDX_CTRL1, {3'b010, m[1], 2'b00, m[0], r[8]});
            chk("fmt", 32'({uart_enable, nine_sel, par_on, par_odd}), 32'({1'b1, m[1], m[0], r[8]}));
            wr(`UCF_IDX_CTRL3, {1'b0, r[0], 6'h00});
            frm_q.push_back(frm(d, r[0], m[1], m[0], r[8]));
            wr(`UCF_IDX_DATA, d);
            wait_frames();
        end
        d = 8'($urandom);
        wr(`UCF_IDX_CTRL1, 8'h52);
        frm_q.push_back(frm(d, 1'b0, 1'b1, 1'b1, 1'b0));
        wr(`UCF_IDX_DATA, d);
        wait_lvl(1'b0);
        wr(`UCF_IDX_CTRL2, 8'h00);
        wait_frames();
        repeat (BC) @(posedge clk);
        hold(1'b1, 30 * BC, bad);
        chk("idle_line", 32'(bad), 32'h0);
        $display("test transmit done");
        listen <= 1'b0;
        wr(`UCF_IDX_CTRL2, 8'h08);
        wr(`UCF_IDX_CTRL2, 8'h09);
        wait_lvl(1'b0);
        hold(1'b0, 20 * BC, bad);
        chk("break_run", 32'(bad), 32'h0);
        wr(`UCF_IDX_CTRL2, 8'h48);
        wait_lvl(1'b1);
        chk("tail_busy", 32'(tx_irq), 32'h0);
        hold(1'b1, BC, bad);
        chk("break_tail", 32'(bad), 32'h0);
        chk("tail_done", 32'(tx_irq), 32'h1);
        repeat (4 * BC) @(posedge clk);
        wr(`UCF_IDX_CTRL2, 8'h88);
        chk("tx_irq_on", 32'(tx_irq), 32'h1);
        wr(`UCF_IDX_CTRL1, 8'h00);
        chk("tx_irq_off", 32'(tx_irq), 32'h0);
        rd(`UCF_IDX_STAT1, 8'hc0);
        $display("test break and disable done");
        give_verdict();
    end
endmodule : tb_uart_control_format
